// [rtl/npic_ctrl.sv]
// Nested priority interrupt controller: arbitration, entry, return, wake
// Assumes the core stacks and fetches as told by the entry strobe
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module npic_ctrl #(
   parameter int NUM_VEC = 14,
   parameter int NUM_EXT = 5,
   parameter int EXT_W   = 8
) (
   // Clock and reset
   input  logic                     core_clk,
   input  logic                     reset_n,
   // Register port
   input  npic_pkg::npic_bus_t      bus,
   output logic [7:0]               rdData_r,
   // Core handshake
   input  logic                     instrEnd,
   input  logic                     trapExec,
   input  logic                     waitEnter,
   input  logic                     haltEnter,
   input  logic                     iretDone,
   input  logic [7:0]               poppedCc,
   output npic_pkg::npic_entry_t    entry_r,
   output logic [7:0]               cc_r,
   output npic_pkg::npic_pwr_t      pwr_r,
   // Pins
   input  logic                     nmiPin,
   input  logic [NUM_EXT*EXT_W-1:0] extPins,
   // Peripherals
   input  logic [NUM_VEC-1:0]       periphFlag,
   input  logic [NUM_VEC-1:0]       periphEn,
   input  logic [NUM_VEC-1:0]       periphClr
);

   localparam int IN_W = NUM_EXT * EXT_W + 1;

   if (NUM_VEC > 16 || NUM_VEC < NUM_EXT + 2 || EXT_W > 8 || EXT_W < 1)
   begin : g_bad_params
      $error("npic_ctrl: unsupported vector or pin counts");
   end

   // ==========================================================
   // Level code helpers
   function automatic logic [1:0] lvlOf(input logic [1:0] code);
      case (code)
         npic_pkg::CODE_L0: lvlOf = 2'h0;
         npic_pkg::CODE_L1: lvlOf = 2'h1;
         npic_pkg::CODE_L2: lvlOf = 2'h2;
         default:           lvlOf = 2'h3;
      endcase
   endfunction

   function automatic logic [1:0] codeOf(input logic [1:0] lvl);
      case (lvl)
         2'h0:    codeOf = npic_pkg::CODE_L0;
         2'h1:    codeOf = npic_pkg::CODE_L1;
         2'h2:    codeOf = npic_pkg::CODE_L2;
         default: codeOf = npic_pkg::CODE_L3;
      endcase
   endfunction

   function automatic logic [7:0] keepL0(input logic [7:0] old,
                                         input logic [7:0] wr);
      logic [7:0] res;
      res = wr;
      for (int i = 0; i < 4; i++) begin
         if (wr[2*i +: 2] == npic_pkg::CODE_L0) begin
            res[2*i +: 2] = old[2*i +: 2];
         end
      end
      return res;
   endfunction

   function automatic logic [7:0] setLvl(input logic [7:0] cc,
                                         input logic [1:0] code);
      logic [7:0] res;
      res = cc;
      res[npic_pkg::CC_HI] = code[1];
      res[npic_pkg::CC_LO] = code[0];
      return res;
   endfunction

   // ==========================================================
   // State
   logic [3:0][7:0]         prio_r;
   logic [NUM_EXT-1:0][7:0] extSel_r;
   logic [7:0]              cfg_r;
   logic [IN_W-1:0]         s1_r;
   logic [IN_W-1:0]         s2_r;
   logic [IN_W-1:0]         s3_r;
   logic [IN_W-1:0]         stab_r;
   logic [IN_W-1:0]         stabPrev_r;
   logic [NUM_EXT-1:0]      extLinePrev_r;
   logic [NUM_VEC-1:0]      pend_r;
   logic                    trapPend_r;
   logic                    resetPend_r;

   // ==========================================================
   // Register decode
   logic [7:0]  selOff;
   logic        hitPrio;
   logic        hitCc;
   logic        hitSel;
   logic        hitCfg;
   logic [1:0]  prioIdx;
   logic [7:0]  prioWr;
   logic [7:0]  rdSel;

   assign selOff  = bus.addr - npic_pkg::ADDR_EXTSEL0;
   assign hitPrio = bus.addr[7:2] == npic_pkg::ADDR_PRIO0[7:2];
   assign hitCc   = bus.addr == npic_pkg::ADDR_CC;
   assign hitSel  = selOff < 8'(NUM_EXT);
   assign hitCfg  = bus.addr == npic_pkg::ADDR_CFG;
   assign prioIdx = bus.addr[1:0];
   assign prioWr  = keepL0(prio_r[prioIdx], bus.data)
                  | ((prioIdx == 2'h3) ? npic_pkg::PRIO3_RO : 8'h00);
   assign rdSel   = hitPrio ? prio_r[prioIdx] :
                    hitCc   ? cc_r :
                    hitSel  ? extSel_r[selOff[2:0]] :
                    hitCfg  ? cfg_r : 8'h00;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         prio_r   <= {4{npic_pkg::RST_PRIO}};
         extSel_r <= {NUM_EXT{npic_pkg::RST_EXTSEL}};
         cfg_r    <= npic_pkg::RST_CFG;
         rdData_r <= 8'h00;
      end else begin
         rdData_r <= bus.rd ? rdSel : 8'h00;
         if (bus.wr && hitPrio) begin
            prio_r[prioIdx] <= prioWr;
         end
         if (bus.wr && hitSel) begin
            extSel_r[selOff[2:0]] <= bus.data;
         end
         if (bus.wr && hitCfg) begin
            cfg_r <= bus.data;
         end
      end
   end

   // ==========================================================
   // Pin synchronisers and edge detection
   logic [IN_W-1:0]    agree;
   logic [IN_W-1:0]    stabNxt;
   logic [NUM_EXT-1:0] extLine;
   logic [NUM_EXT-1:0] extRise;
   logic               nmiNow;
   logic               nmiOld;
   logic               nmiEdge;

   assign agree   = s2_r ~^ s3_r;
   assign stabNxt = (agree & s3_r) | (~agree & stab_r);
   assign nmiNow  = stab_r[IN_W-1];
   assign nmiOld  = stabPrev_r[IN_W-1];
   assign nmiEdge = cfg_r[npic_pkg::CFG_NMI_RISE] ? (nmiNow & ~nmiOld)
                                                  : (~nmiNow & nmiOld);

   for (genvar g = 0; g < NUM_EXT; g++) begin : g_ext
      assign extLine[g] = |(stab_r[g*EXT_W +: EXT_W]
                          & extSel_r[g][EXT_W-1:0]);
   end
   assign extRise = extLine & ~extLinePrev_r;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_r          <= '0;
         s2_r          <= '0;
         s3_r          <= '0;
         stab_r        <= '0;
         stabPrev_r    <= '0;
         extLinePrev_r <= '0;
      end else begin
         s1_r          <= {nmiPin, extPins};
         s2_r          <= s1_r;
         s3_r          <= s2_r;
         stab_r        <= stabNxt;
         stabPrev_r    <= stab_r;
         extLinePrev_r <= extLine;
      end
   end

   // ==========================================================
   // Request latching and candidates
   logic [NUM_VEC-1:0] perMask;
   logic [NUM_VEC-1:0] wakeMask;
   logic [NUM_VEC-1:0] enMask;
   logic [NUM_VEC-1:0] setVec;
   logic [NUM_VEC-1:0] reqVec;
   logic [NUM_VEC-1:0] cand;
   logic [NUM_VEC-1:0] takeHot;
   logic [NUM_VEC-1:0] pendNxt;
   logic [1:0]         vecLvl [NUM_VEC];
   logic [1:0]         curLvl;
   logic               halted;

   assign perMask  = npic_pkg::PERIPH_MASK[NUM_VEC-1:0];
   assign wakeMask = npic_pkg::HALT_WAKE[NUM_VEC-1:0];
   assign enMask   = perMask | NUM_VEC'({cfg_r[NUM_EXT-1:0], 1'b1});
   assign setVec   = NUM_VEC'({extRise, nmiEdge})
                   | (periphFlag & periphEn & perMask);
   assign reqVec   = pend_r & (~perMask | (periphFlag & periphEn));
   assign curLvl   = lvlOf({cc_r[npic_pkg::CC_HI], cc_r[npic_pkg::CC_LO]});
   assign halted   = pwr_r == npic_pkg::PWR_HALT;
   assign pendNxt  = setVec
                   | (pend_r & ~(takeHot | (periphClr & perMask)));

   for (genvar v = 0; v < NUM_VEC; v++) begin : g_vec
      assign vecLvl[v] = lvlOf(prio_r[v/4][(v%4)*2 +: 2]);
      assign cand[v]   = reqVec[v] & enMask[v]
                       & (vecLvl[v] > curLvl)
                       & (~halted | wakeMask[v]);
   end

   // ==========================================================
   // Arbitration
   logic [3:0]  winIdx;
   logic [1:0]  winLvl;
   logic        winAny;
   logic        rstWin;
   logic        trapWin;
   logic        nmiWin;
   logic        maskWin;
   logic        winValid;
   logic        take;
   logic [15:0] winAddr;
   logic [1:0]  winCode;

   always_comb begin
      winIdx = 4'h0;
      winLvl = 2'h0;
      winAny = 1'b0;
      for (int v = NUM_VEC - 1; v >= 1; v--) begin
         if (cand[v] && (!winAny || vecLvl[v] >= winLvl)) begin
            winAny = 1'b1;
            winLvl = vecLvl[v];
            winIdx = 4'(v);
         end
      end
   end

   assign rstWin   = resetPend_r;
   assign trapWin  = ~rstWin & trapPend_r;
   assign nmiWin   = ~rstWin & ~trapWin & reqVec[0];
   assign maskWin  = ~rstWin & ~trapWin & ~nmiWin & winAny;
   assign winValid = rstWin | trapWin | nmiWin | maskWin;
   assign take     = winValid & (instrEnd | rstWin
                   | (pwr_r != npic_pkg::PWR_RUN));
   assign winAddr  = rstWin  ? npic_pkg::VEC_RESET :
                     trapWin ? npic_pkg::VEC_TRAP :
                     nmiWin  ? npic_pkg::VEC_BASE :
                     npic_pkg::VEC_BASE - {11'h000, winIdx, 1'b0};
   assign winCode  = maskWin ? codeOf(winLvl) : npic_pkg::CODE_L3;
   assign takeHot  = (take & (maskWin | nmiWin))
                   ? NUM_VEC'(1) << (nmiWin ? 4'h0 : winIdx) : '0;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pend_r      <= '0;
         trapPend_r  <= 1'b0;
         resetPend_r <= 1'b1;
      end else begin
         pend_r      <= pendNxt;
         trapPend_r  <= trapExec | (trapPend_r & ~(take & trapWin));
         resetPend_r <= resetPend_r & ~take;
      end
   end

   // ==========================================================
   // Entry, return and power state
   logic [7:0]            ccNxt;
   npic_pkg::npic_pwr_t   pwrNxt;
   npic_pkg::npic_entry_t entryNxt;

   assign ccNxt = take ? setLvl(cc_r, winCode) :
                  iretDone ? (poppedCc | npic_pkg::CC_FIXED) :
                  (bus.wr && hitCc) ? (bus.data | npic_pkg::CC_FIXED) :
                  (waitEnter | haltEnter) ? setLvl(cc_r, npic_pkg::CODE_L0)
                  : cc_r;
   assign entryNxt = take ? npic_pkg::npic_entry_t'{take: 1'b1, stack: ~rstWin,
                              vecAddr: winAddr, code: winCode} : '0;

   always_comb begin
      pwrNxt = pwr_r;
      case (pwr_r)
         npic_pkg::PWR_RUN: begin
            if (waitEnter) begin
               pwrNxt = npic_pkg::PWR_WAIT;
            end else if (haltEnter) begin
               pwrNxt = npic_pkg::PWR_HALT;
            end
         end
         npic_pkg::PWR_WAIT,
         npic_pkg::PWR_HALT: begin
            if (take) begin
               pwrNxt = npic_pkg::PWR_RUN;
            end
         end
         default: pwrNxt = npic_pkg::PWR_RUN;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cc_r    <= npic_pkg::RST_CC;
         pwr_r   <= npic_pkg::PWR_RUN;
         entry_r <= '0;
      end else begin
         cc_r    <= ccNxt;
         pwr_r   <= pwrNxt;
         entry_r <= entryNxt;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sequence s_reset_taken;
      entry_r.take && entry_r.vecAddr == npic_pkg::VEC_RESET
      && !entry_r.stack;
   endsequence

   sequence s_trap_seen;
      trapExec ##1 trapPend_r;
   endsequence

   a_take_boundary: assert property (
      entry_r.take |-> $past(instrEnd) || $past(rstWin)
      || ($past(pwr_r) != npic_pkg::PWR_RUN))
      else $error("entry outside an instruction boundary");

   a_stack_push: assert property (
      entry_r.take |-> entry_r.stack
      == (entry_r.vecAddr != npic_pkg::VEC_RESET))
      else $error("stacking flag wrong for vector");

   a_level_load: assert property (
      entry_r.take |-> cc_r[npic_pkg::CC_HI] == entry_r.code[1]
      && cc_r[npic_pkg::CC_LO] == entry_r.code[0])
      else $error("level bits not loaded on entry");

   a_vector_range: assert property (
      entry_r.take |-> entry_r.vecAddr >= npic_pkg::VEC_FLOOR
      && !entry_r.vecAddr[0])
      else $error("vector address out of table");

   a_return_from_handler_instr_restore: assert property (
      iretDone && !take |=> (cc_r & npic_pkg::CC_PRIO_MASK)
      == ($past(poppedCc) & npic_pkg::CC_PRIO_MASK))
      else $error("return did not restore level");

   a_cc_reset: assert property (
      resetPend_r |-> cc_r == npic_pkg::RST_CC)
      else $error("condition code not at reset value");

   a_reset_entry: assert property (
      resetPend_r |=> s_reset_taken)
      else $error("reset vector not entered first");

   a_nonmask_level: assert property (
      take && !maskWin |=> entry_r.code == npic_pkg::CODE_L3
      && cc_r[npic_pkg::CC_HI] && cc_r[npic_pkg::CC_LO])
      else $error("non-maskable entry not at level 3");

   a_mask_above: assert property (
      take && maskWin |=> lvlOf(entry_r.code) > $past(curLvl))
      else $error("maskable entry not above current level");

   a_halt_wake: assert property (
      take && halted |-> !maskWin || wakeMask[winIdx])
      else $error("non-wake source served first after halt");

   a_trap_latch: assert property (
      trapExec |-> s_trap_seen)
      else $error("trap request not latched");

   a_edge_clear: assert property (
      take && maskWin && winIdx == 4'h1 && !setVec[1] |=> !pend_r[1])
      else $error("edge request not cleared on entry");

   a_prio_keep: assert property (
      bus.wr && bus.addr == npic_pkg::ADDR_PRIO0
      && bus.data[1:0] == npic_pkg::CODE_L0
      |=> prio_r[0][1:0] == $past(prio_r[0][1:0]))
      else $error("level 0 code was stored");

endmodule

// [rtl/npic_pkg.sv]
// Constants, types and layout of the nested priority interrupt controller
// Assumes an 8-bit core that reports instruction boundaries and returns
package npic_pkg;

   // ==========================================================
   // Register offsets, reset values and read-only bits
   localparam logic [7:0]  ADDR_PRIO0   = 8'h1c;
   localparam logic [7:0]  ADDR_CC      = 8'h20;
   localparam logic [7:0]  ADDR_EXTSEL0 = 8'h21;
   localparam logic [7:0]  ADDR_CFG     = 8'h28;
   localparam logic [7:0]  RST_PRIO     = 8'hff;
   localparam logic [7:0]  RST_CC       = 8'hea;
   localparam logic [7:0]  RST_EXTSEL   = 8'h00;
   localparam logic [7:0]  RST_CFG      = 8'h00;
   localparam logic [7:0]  PRIO3_RO     = 8'hf0;

   // ==========================================================
   // Condition code and configuration fields
   localparam int          CC_HI        = 5;
   localparam int          CC_LO        = 3;
   localparam logic [7:0]  CC_FIXED     = 8'hc0;
   localparam logic [7:0]  CC_PRIO_MASK = 8'h28;
   localparam int          CFG_NMI_RISE = 7;

   // ==========================================================
   // Level codes
   localparam logic [1:0]  CODE_L0      = 2'h2;
   localparam logic [1:0]  CODE_L1      = 2'h1;
   localparam logic [1:0]  CODE_L2      = 2'h0;
   localparam logic [1:0]  CODE_L3      = 2'h3;

   // ==========================================================
   // Vectors and source classes
   localparam logic [15:0] VEC_RESET    = 16'hfffe;
   localparam logic [15:0] VEC_TRAP     = 16'hfffc;
   localparam logic [15:0] VEC_BASE     = 16'hfffa;
   localparam logic [15:0] VEC_FLOOR    = 16'hffe0;
   localparam logic [15:0] PERIPH_MASK  = 16'h3f40;
   localparam logic [15:0] HALT_WAKE    = 16'h007f;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {PWR_RUN, PWR_WAIT, PWR_HALT} npic_pwr_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [7:0]  data;
   } npic_bus_t;

   typedef struct packed {
      logic        take;
      logic        stack;
      logic [15:0] vecAddr;
      logic [1:0]  code;
   } npic_entry_t;

endpackage

// [bench/npic_core_model.sv]
// Behavioural core facing the interrupt controller
// Assumes the controller ports of npic_ctrl and the package npic_pkg
`timescale 1ns/1ns
module npic_core_model (
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  reset_n,
   // Controller side
   input  wire npic_pkg::npic_entry_t entry,
   input  wire logic [7:0]            ccNow,
   input  wire npic_pkg::npic_pwr_t   pwr,
   output logic                       instrEnd,
   output logic                       trapExec,
   output logic                       iretDone,
   output logic [7:0]                 poppedCc,
   // Bench commands
   input  wire logic                  doIret,
   input  wire logic                  doTrap,
   input  wire logic [3:0]            gap
);
   logic [7:0] ccStack[$];
   logic [7:0] ccPrev, pcN;
   logic [3:0] cnt;
   logic       iretReq, trapReq, ieN, teN, idN;

   // ==========================================================
   // Instruction flow, stacking and return
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ccStack.delete();
         iretReq = 1'b0;
         trapReq = 1'b0;
         cnt = 4'h0;
         ccPrev <= 8'h00;
         instrEnd <= 1'b0;
         trapExec <= 1'b0;
         iretDone <= 1'b0;
         poppedCc <= 8'h00;
      end else begin
         iretReq = iretReq | doIret;
         trapReq = trapReq | doTrap;
         ieN = 1'b0;
         teN = 1'b0;
         idN = 1'b0;
         pcN = ~poppedCc;
         if (entry.take) begin
            if (entry.stack) begin
               ccStack.push_back(ccPrev);
            end
            cnt = 4'h3;
         end else if (cnt != 4'h0) begin
            cnt = cnt - 4'h1;
         end else if (pwr == npic_pkg::PWR_RUN) begin
            cnt = gap;
            if (iretReq && ccStack.size() > 0) begin
               iretReq = 1'b0;
               idN = 1'b1;
               pcN = ccStack.pop_back();
            end else begin
               ieN = 1'b1;
               teN = trapReq;
               trapReq = 1'b0;
            end
         end
         ccPrev <= ccNow;
         instrEnd <= ieN;
         trapExec <= teN;
         iretDone <= idN;
         poppedCc <= pcN;
      end
   end
endmodule

// [bench/npic_ctrl_tb.sv]
// Self-checking bench for the nested priority interrupt controller
// Assumes npic_core_model as the core and default controller parameters
`timescale 1ns/1ns
`define CHK(what, exp, got) \
   begin \
      samplesChecked++; \
      if ((got) !== (exp)) begin \
         nMismatch++; \
         $display("BAD %s exp %h got %h", what, exp, got); \
      end \
   end
module npic_ctrl_tb;
   logic                  core_clk, reset_n;
   npic_pkg::npic_bus_t   bus;
   npic_pkg::npic_entry_t entry, lastEnt;
   npic_pkg::npic_pwr_t   pwr;
   logic [7:0]            rdData, ccReg, poppedCc, lastCc;
   logic                  instrEnd, trapExec, iretDone, waitEnter;
   logic                  haltEnter, nmiPin, doIret, doTrap;
   logic [3:0]            gap;
   logic [39:0]           extPins;
   logic [13:0]           periphFlag, periphEn, periphClr;
   int                    nMismatch, samplesChecked, nTake, seenTake;

   // ==========================================================
   // Design, core model and clock
   npic_ctrl dut (.core_clk(core_clk), .reset_n(reset_n), .bus(bus),
      .rdData_r(rdData), .instrEnd(instrEnd), .trapExec(trapExec),
      .waitEnter(waitEnter), .haltEnter(haltEnter), .iretDone(iretDone),
      .poppedCc(poppedCc), .entry_r(entry), .cc_r(ccReg), .pwr_r(pwr),
      .nmiPin(nmiPin), .extPins(extPins), .periphFlag(periphFlag),
      .periphEn(periphEn), .periphClr(periphClr));
   npic_core_model core (.core_clk(core_clk), .reset_n(reset_n),
      .entry(entry), .ccNow(ccReg), .pwr(pwr), .instrEnd(instrEnd),
      .trapExec(trapExec), .iretDone(iretDone), .poppedCc(poppedCc),
      .doIret(doIret), .doTrap(doTrap), .gap(gap));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (entry.take === 1'b1) begin
         nTake++;
         lastEnt = entry;
         lastCc = ccReg;
      end
   end

   // ==========================================================
   // Tasks
   task automatic wrapUp();
      $display("Checks %0d mismatches %0d", samplesChecked, nMismatch);
      if (nMismatch == 0 && samplesChecked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
      @(posedge core_clk);
      bus <= '0;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
      @(posedge core_clk);
      bus <= '0;
      @(negedge core_clk);
      `CHK("read data", exp, rdData)
   endtask
   task automatic expTake(input logic [15:0] v, input logic [1:0] c,
                          input logic s);
      int k;
      k = 0;
      while (nTake == seenTake && k < 300) begin
         @(negedge core_clk);
         k++;
      end
      if (nTake == seenTake) begin
         `CHK("entry wait", 1'b1, 1'b0)
         wrapUp();
      end else begin
         `CHK("entry", {v, c, s, c},
           {lastEnt.vecAddr, lastEnt.code, lastEnt.stack, lastCc[5], lastCc[3]})
         seenTake = nTake;
      end
   endtask
   task automatic expNone();
      repeat (20) @(negedge core_clk);
      `CHK("no entry", seenTake, nTake)
   endtask
   task automatic ret(input logic [7:0] expCc);
      int k;
      k = 0;
      @(posedge core_clk);
      doIret <= 1'b1;
      @(posedge core_clk);
      doIret <= 1'b0;
      while (iretDone !== 1'b1 && k < 100) begin
         @(negedge core_clk);
         k++;
      end
      if (iretDone !== 1'b1) begin
         `CHK("return wait", 1'b1, 1'b0)
         wrapUp();
      end else begin
         @(negedge core_clk);
         `CHK("cc after return", expCc, ccReg)
      end
   endtask
   task automatic cmd(input logic [2:0] c);
      @(posedge core_clk);
      {doTrap, waitEnter, haltEnter} <= c;
      @(posedge core_clk);
      {doTrap, waitEnter, haltEnter} <= 3'h0;
      @(negedge core_clk);
   endtask
   task automatic setPer(input logic [13:0] f, input logic [13:0] e);
      @(posedge core_clk);
      periphFlag <= f;
      periphEn <= e;
   endtask
   task automatic clrSrc(input int v);
      @(posedge core_clk);
      periphFlag[v] <= 1'b0;
      periphClr[v] <= 1'b1;
      @(posedge core_clk);
      periphClr <= '0;
   endtask
   task automatic setPins(input logic [7:0] p);
      @(posedge core_clk);
      extPins[7:0] <= p;
      repeat (6) @(posedge core_clk);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      {reset_n, nmiPin, doIret, doTrap, waitEnter, haltEnter} = 6'h00;
      bus = '0;
      gap = 4'h0;
      extPins = '0;
      {periphFlag, periphEn, periphClr} = '0;
      {nMismatch, samplesChecked, nTake, seenTake} = '0;
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      expTake(16'hfffe, 2'h3, 1'b0);
      rdChk(8'h20, 8'hea);
      for (int a = 0; a < 4; a++) begin
         rdChk(8'h1c + 8'(a), 8'hff);
      end
      rdChk(8'h30, 8'h00);
      wrReg(8'h1c, 8'hcf);
      wrReg(8'h1c, 8'h64);
      wrReg(8'h1c, 8'h46);
      rdChk(8'h1c, 8'h44);
      wrReg(8'h1f, 8'h04);
      rdChk(8'h1f, 8'hf4);
      wrReg(8'h1e, 8'h05);
      cmd(3'h4);
      expTake(16'hfffc, 2'h3, 1'b1);
      ret(8'hea);
      wrReg(8'h20, 8'he2);
      rdChk(8'h20, 8'he2);
      setPer(14'h3d00, 14'h1d00);
      expTake(16'hffe6, 2'h0, 1'b1);
      expNone();
      clrSrc(10);
      ret(8'he2);
      expTake(16'hffe4, 2'h0, 1'b1);
      clrSrc(11);
      ret(8'he2);
      expTake(16'hffe2, 2'h0, 1'b1);
      clrSrc(12);
      ret(8'he2);
      expTake(16'hffea, 2'h1, 1'b1);
      setPer(14'h2500, 14'h1d00);
      expTake(16'hffe6, 2'h0, 1'b1);
      clrSrc(10);
      ret(8'hca);
      clrSrc(8);
      ret(8'he2);
      wrReg(8'h28, 8'h81);
      wrReg(8'h21, 8'h03);
      @(posedge core_clk);
      nmiPin <= 1'b1;
      expTake(16'hfffa, 2'h3, 1'b1);
      ret(8'he2);
      setPins(8'h02);
      expTake(16'hfff8, 2'h1, 1'b1);
      ret(8'he2);
      expNone();
      setPins(8'h03);
      expNone();
      setPins(8'h00);
      setPins(8'h01);
      expTake(16'hfff8, 2'h1, 1'b1);
      ret(8'he2);
      cmd(3'h1);
      `CHK("halt state", npic_pkg::PWR_HALT, pwr)
      setPer(14'h2200, 14'h0200);
      expNone();
      setPins(8'h00);
      setPins(8'h01);
      expTake(16'hfff8, 2'h1, 1'b1);
      `CHK("run state", npic_pkg::PWR_RUN, pwr)
      ret(8'he2);
      expTake(16'hffe8, 2'h1, 1'b1);
      clrSrc(9);
      ret(8'he2);
      cmd(3'h1);
      @(posedge core_clk);
      nmiPin <= 1'b0;
      repeat (6) @(posedge core_clk);
      nmiPin <= 1'b1;
      expTake(16'hfffa, 2'h3, 1'b1);
      `CHK("run state", npic_pkg::PWR_RUN, pwr)
      ret(8'he2);
      @(posedge core_clk);
      gap <= 4'h3;
      cmd(3'h2);
      `CHK("wait state", npic_pkg::PWR_WAIT, pwr)
      setPer(14'h2200, 14'h0200);
      expTake(16'hffe8, 2'h1, 1'b1);
      clrSrc(9);
      ret(8'he2);
      wrReg(8'h20, 8'hea);
      setPer(14'h2200, 14'h0200);
      expNone();
      wrReg(8'h20, 8'he2);
      expTake(16'hffe8, 2'h1, 1'b1);
      clrSrc(9);
      ret(8'he2);
      wrapUp();
   end
endmodule
